// ==== pkg/clif_map.svh ====
`ifndef CLIF_MAP_SVH
`define CLIF_MAP_SVH
`define CLIF_WORD_W 12
`define CLIF_ADDR_W 9
`define CLIF_KIND_MSB 11
`define CLIF_KIND_LSB 9
`define CLIF_KIND_COEF 3'h0
`define CLIF_KIND_CONFIG 3'h1
`define CLIF_KIND_HSEL 3'h2
`define CLIF_KIND_VSEL 3'h3
`define CLIF_KIND_HRND 3'h4
`define CLIF_KIND_VRND 3'h5
`define CLIF_KIND_HLIM 3'h6
`define CLIF_KIND_VLIM 3'h7
`define CLIF_NUM_COEF 4'h8
`define CLIF_NUM_ONE 4'h1
`define CLIF_NUM_RND 4'h4
`define CLIF_NUM_LIM 4'h2
`define CLIF_RND_BYTE_W 8
`define CLIF_CTRL_DATA_W 32
`define CLIF_FIFO_DEPTH 32
`endif

// ==== pkg/clif_pkg.sv ====
`include "clif_map.svh"
package clif_pkg;
  typedef enum logic [2:0] {
    KIND_COEF = `CLIF_KIND_COEF,
    KIND_CONFIG = `CLIF_KIND_CONFIG,
    KIND_HSEL = `CLIF_KIND_HSEL,
    KIND_VSEL = `CLIF_KIND_VSEL,
    KIND_HRND = `CLIF_KIND_HRND,
    KIND_VRND = `CLIF_KIND_VRND,
    KIND_HLIM = `CLIF_KIND_HLIM,
    KIND_VLIM = `CLIF_KIND_VLIM
  } clif_kind_type;
  typedef enum logic [1:0] {
    ST_ADDR = 2'h1,
    ST_DATA = 2'h2
  } clif_state_type;
  typedef struct packed {
    clif_kind_type kind;
    logic [`CLIF_ADDR_W-1:0] addr;
    logic [`CLIF_CTRL_DATA_W-1:0] data;
  } clif_rec_type;
endpackage

// ==== design/clif_top.sv ====
`timescale 1ns/1ps
`include "clif_map.svh"

module clif_fifo #(
  parameter int W = 8,
  parameter int DEPTH = `CLIF_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [W-1:0] inData,
  // Drain side
  output logic outValid,
  input wire logic outReady,
  output logic [W-1:0] outData
);
  localparam int PW = $clog2(DEPTH);
  generate
    if (DEPTH < 2) begin : g_chk
      $error("clif_fifo: DEPTH must be at least 2");
    end
  endgenerate
  logic [W-1:0] memQ [DEPTH];
  logic [PW-1:0] wrQ;
  logic [PW-1:0] rdQ;
  logic [PW:0] cntQ;
  wire push = inValid & inReady;
  wire pop = outValid & outReady;
  wire [PW-1:0] wrNext = (wrQ == PW'(DEPTH - 1)) ? '0 : wrQ + 1'b1;
  wire [PW-1:0] rdNext = (rdQ == PW'(DEPTH - 1)) ? '0 : rdQ + 1'b1;
  assign inReady = (cntQ != (PW + 1)'(DEPTH));
  assign outValid = (cntQ != '0);
  assign outData = memQ[rdQ];
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wrQ <= '0;
      rdQ <= '0;
      cntQ <= '0;
    end else begin
      if (push) wrQ <= wrNext;
      if (pop) rdQ <= rdNext;
      if (push != pop) cntQ <= push ? cntQ + 1'b1 : cntQ - 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (push) memQ[wrQ] <= inData;
  end
endmodule // clif_fifo

module clif_port #(
  parameter int WORD_W = `CLIF_WORD_W,
  parameter int BANKS = `CLIF_NUM_COEF
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Load pins and queue stall
  input wire logic loadStrobe_n,
  input wire logic [WORD_W-1:0] loadWord,
  input wire logic loadHold,
  input wire logic stall,
  // Committed transfer
  output logic commit,
  output clif_pkg::clif_rec_type commitRec,
  output logic [BANKS*WORD_W-1:0] coefData
);
  generate
    if (WORD_W != `CLIF_WORD_W || BANKS != `CLIF_NUM_COEF) begin : g_chk
      $error("clif_port: word layout is fixed by the address format");
    end
  endgenerate
  clif_pkg::clif_state_type stateQ;
  clif_pkg::clif_kind_type kindQ;
  logic [`CLIF_ADDR_W-1:0] addrQ;
  logic [3:0] needQ;
  logic [3:0] countQ;
  logic commitQ;
  logic [WORD_W-1:0] bufQ [BANKS];
  // Stall and hold both freeze the port without eating a word
  wire take = ~loadStrobe_n & ~loadHold & ~stall;
  wire isAddr = (stateQ == clif_pkg::ST_ADDR);
  wire [2:0] kindIn = loadWord[`CLIF_KIND_MSB:`CLIF_KIND_LSB];
  wire kindRnd = (kindIn == `CLIF_KIND_HRND) | (kindIn == `CLIF_KIND_VRND);
  wire kindLim = (kindIn == `CLIF_KIND_HLIM) | (kindIn == `CLIF_KIND_VLIM);
  wire [3:0] needIn = (kindIn == `CLIF_KIND_COEF) ? `CLIF_NUM_COEF :
    kindRnd ? `CLIF_NUM_RND : kindLim ? `CLIF_NUM_LIM : `CLIF_NUM_ONE;
  wire lastWord = (countQ == needQ - 4'h1);
  wire qRnd = (kindQ == clif_pkg::KIND_HRND) | (kindQ == clif_pkg::KIND_VRND);
  wire qLim = (kindQ == clif_pkg::KIND_HLIM) | (kindQ == clif_pkg::KIND_VLIM);
  wire [`CLIF_CTRL_DATA_W-1:0] rndVal = {bufQ[3][`CLIF_RND_BYTE_W-1:0],
    bufQ[2][`CLIF_RND_BYTE_W-1:0], bufQ[1][`CLIF_RND_BYTE_W-1:0],
    bufQ[0][`CLIF_RND_BYTE_W-1:0]};
  wire [`CLIF_CTRL_DATA_W-1:0] limVal = {8'h00, bufQ[1], bufQ[0]};
  wire [`CLIF_CTRL_DATA_W-1:0] oneVal = {20'h00000, bufQ[0]};
  assign commit = commitQ;
  assign commitRec.kind = kindQ;
  assign commitRec.addr = addrQ;
  assign commitRec.data = qRnd ? rndVal : qLim ? limVal : oneVal;
  genvar gi;
  for (gi = 0; gi < BANKS; gi++) begin : g_pack
    assign coefData[gi*WORD_W +: WORD_W] = bufQ[gi];
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stateQ <= clif_pkg::ST_ADDR;
      kindQ <= clif_pkg::KIND_COEF;
      addrQ <= '0;
      needQ <= `CLIF_NUM_ONE;
      countQ <= '0;
      commitQ <= 1'b0;
    end else if (loadStrobe_n) begin
      stateQ <= clif_pkg::ST_ADDR;
      countQ <= '0;
      commitQ <= 1'b0;
    end else begin
      commitQ <= 1'b0;
      if (take && isAddr) begin
        stateQ <= clif_pkg::ST_DATA;
        kindQ <= clif_pkg::clif_kind_type'(kindIn);
        addrQ <= loadWord[`CLIF_ADDR_W-1:0];
        needQ <= needIn;
        countQ <= '0;
      end else if (take) begin
        if (lastWord) begin
          commitQ <= 1'b1;
          stateQ <= clif_pkg::ST_ADDR;
          countQ <= '0;
        end else begin
          countQ <= countQ + 4'h1;
        end
      end
    end
  end
  // Data words are not reset: nothing reads them before a commit
  always_ff @(posedge clk) begin
    if (take && !isAddr) bufQ[countQ[2:0]] <= loadWord;
  end

  // Word-count checks assume back-to-back words; a hold or stall ends the chain
  defer_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    commitQ |-> $past(take) && $past(stateQ) == clif_pkg::ST_DATA
      && $past(countQ) == $past(needQ) - 4'h1)
    else $error("write committed before last data word");
  new_addr_a: assert property (@(posedge clk) disable iff (!rst_n)
    commitQ && take |=> stateQ == clif_pkg::ST_DATA)
    else $error("word after last data not taken as address");
  idle_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    loadStrobe_n |=> stateQ == clif_pkg::ST_ADDR && countQ == 4'h0 && !commitQ)
    else $error("port not idle while strobe high");
  hold_freeze_a: assert property (@(posedge clk) disable iff (!rst_n)
    !loadStrobe_n && loadHold |=> $stable(stateQ) && $stable(countQ) && !commitQ)
    else $error("port advanced during hold");
  stall_freeze_a: assert property (@(posedge clk) disable iff (!rst_n)
    !loadStrobe_n && stall |=> $stable(stateQ) && $stable(countQ) && !commitQ)
    else $error("port advanced while the queue had no room");
  addr_latch_a: assert property (@(posedge clk) disable iff (!rst_n)
    take && isAddr |=> stateQ == clif_pkg::ST_DATA
      && addrQ == $past(loadWord[`CLIF_ADDR_W-1:0]))
    else $error("address word not latched");
  coef_nine_a: assert property (@(posedge clk) disable iff (!rst_n)
    (take && isAddr && kindIn == `CLIF_KIND_COEF) ##1 take [*8] |=> commitQ)
    else $error("coefficient set not committed after nine words");
  round_five_a: assert property (@(posedge clk) disable iff (!rst_n)
    (take && isAddr && kindRnd) ##1 (take && !commitQ) [*4] |=> commitQ)
    else $error("round register not committed after five words");
  limit_three_a: assert property (@(posedge clk) disable iff (!rst_n)
    (take && isAddr && kindLim) ##1 (take && !commitQ) [*2] |=> commitQ)
    else $error("limit register not committed after three words");
  round_msb_a: assert property (@(posedge clk) disable iff (!rst_n)
    take && !isAddr && qRnd && countQ == 4'h3 |=> commitQ
      && commitRec.data[31:24] == $past(loadWord[7:0]))
    else $error("round register byte order wrong");
  limit_upper_a: assert property (@(posedge clk) disable iff (!rst_n)
    take && !isAddr && qLim && countQ == 4'h1 |=> commitQ
      && commitRec.data[23:12] == $past(loadWord))
    else $error("upper limit misplaced");
  limit_lower_a: assert property (@(posedge clk) disable iff (!rst_n)
    (take && !isAddr && qLim && countQ == 4'h0) ##1 take |=> commitQ
      && commitRec.data[11:0] == $past(loadWord, 2))
    else $error("lower limit misplaced");
  round_lsb_a: assert property (@(posedge clk) disable iff (!rst_n)
    (take && !isAddr && qRnd && countQ == 4'h0) ##1 take [*3] |=> commitQ
      && commitRec.data[7:0] == $past(loadWord[7:0], 4))
    else $error("round register low byte misplaced");
  sel_one_a: assert property (@(posedge clk) disable iff (!rst_n)
    (take && isAddr && needIn == `CLIF_NUM_ONE) ##1 take |=> commitQ)
    else $error("single-word register not committed after one word");
  coef_load_c: cover property (@(posedge clk) disable iff (!rst_n)
    commitQ && kindQ == clif_pkg::KIND_COEF);
  round_load_c: cover property (@(posedge clk) disable iff (!rst_n)
    commitQ && qRnd);
  limit_load_c: cover property (@(posedge clk) disable iff (!rst_n)
    commitQ && qLim);
endmodule // clif_port

module clif_top #(
  parameter int FIFO_DEPTH = `CLIF_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Horizontal load port
  input wire logic horiz_load_strobe_n,
  input wire logic [`CLIF_WORD_W-1:0] horiz_load_word,
  input wire logic horiz_load_hold,
  // Vertical load port
  input wire logic vert_load_strobe_n,
  input wire logic [`CLIF_WORD_W-1:0] vert_load_word,
  input wire logic vert_load_hold,
  // Room for another control write; low stalls both ports
  output logic loadReady,
  // Horizontal coefficient bank write
  output logic horizCoefWrite,
  output logic [`CLIF_ADDR_W-1:0] horizCoefAddr,
  output logic [`CLIF_NUM_COEF*`CLIF_WORD_W-1:0] horizCoefData,
  // Vertical coefficient bank write
  output logic vertCoefWrite,
  output logic [`CLIF_ADDR_W-1:0] vertCoefAddr,
  output logic [`CLIF_NUM_COEF*`CLIF_WORD_W-1:0] vertCoefData,
  // Control register writes
  output logic ctrlValid,
  input wire logic ctrlReady,
  output clif_pkg::clif_rec_type ctrlRec
);
  localparam int RW = $bits(clif_pkg::clif_rec_type);
  logic hCommit;
  logic vCommit;
  clif_pkg::clif_rec_type hRec;
  clif_pkg::clif_rec_type vRec;
  logic fifoReady;
  // Each port has its own sequencer, but both share the stall, and a control-write clash drops the horizontal one
  clif_port u_horiz (
    .clk(clk),
    .rst_n(rst_n),
    .loadStrobe_n(horiz_load_strobe_n),
    .loadWord(horiz_load_word),
    .loadHold(horiz_load_hold),
    .stall(~loadReady),
    .commit(hCommit),
    .commitRec(hRec),
    .coefData(horizCoefData)
  );
  clif_port u_vert (
    .clk(clk),
    .rst_n(rst_n),
    .loadStrobe_n(vert_load_strobe_n),
    .loadWord(vert_load_word),
    .loadHold(vert_load_hold),
    .stall(~loadReady),
    .commit(vCommit),
    .commitRec(vRec),
    .coefData(vertCoefData)
  );
  // Coefficient kind targets the port's own filter only
  wire hCoef = hCommit & (hRec.kind == clif_pkg::KIND_COEF);
  wire vCoef = vCommit & (vRec.kind == clif_pkg::KIND_COEF);
  wire hCtrl = hCommit & ~hCoef;
  wire vCtrl = vCommit & ~vCoef;
  // Horizontal loser is simply dropped; its port already moved on
  wire ctrlPush = vCtrl | hCtrl;
  wire [RW-1:0] ctrlIn = vCtrl ? vRec : hRec;
  assign horizCoefWrite = hCoef;
  assign horizCoefAddr = hRec.addr;
  assign vertCoefWrite = vCoef;
  assign vertCoefAddr = vRec.addr;
  // Queue fill is mirrored here: a commit still in flight must keep its slot,
  // else a last word taken just as the queue fills would be lost
  localparam int FW = $clog2(FIFO_DEPTH) + 1;
  logic [FW-1:0] fillQ;
  wire ctrlPop = ctrlValid & ctrlReady;
  wire ctrlTaken = ctrlPush & fifoReady;
  wire [FW:0] fillAhead = {1'b0, fillQ} + {{FW{1'b0}}, ctrlPush};
  assign loadReady = (fillAhead < (FW + 1)'(FIFO_DEPTH));
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fillQ <= '0;
    end else if (ctrlTaken != ctrlPop) begin
      fillQ <= ctrlTaken ? fillQ + 1'b1 : fillQ - 1'b1;
    end
  end
  clif_fifo #(.W(RW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .inValid(ctrlPush),
    .inReady(fifoReady),
    .inData(ctrlIn),
    .outValid(ctrlValid),
    .outReady(ctrlReady),
    .outData(ctrlRec)
  );

  vert_wins_a: assert property (@(posedge clk) disable iff (!rst_n)
    vCtrl && hCtrl |-> ctrlPush && ctrlIn == RW'(vRec))
    else $error("vertical control write lost to horizontal");
  coef_own_a: assert property (@(posedge clk) disable iff (!rst_n)
    horizCoefWrite |-> hCommit && !(ctrlPush && ctrlIn == RW'(hRec) && !vCtrl))
    else $error("coefficient write routed to control path");
  clash_c: cover property (@(posedge clk) disable iff (!rst_n) vCtrl && hCtrl);
  push_room_a: assert property (@(posedge clk) disable iff (!rst_n)
    ctrlPush |-> fifoReady)
    else $error("control write dropped for want of room");
  stall_c: cover property (@(posedge clk) disable iff (!rst_n)
    !loadReady && !horiz_load_strobe_n);
endmodule // clif_top

// ==== bench/clif_host.sv ====
`timescale 1ns/1ps
module clif_host (
  // Clock and flow
  input wire logic clk,
  input wire logic loadReady,
  // Job from the bench
  input wire logic start,
  input wire logic [4:0] len,
  input wire logic [215:0] words,
  input wire logic slow,
  // Load pins and busy flag
  output logic strobe_n = 1'b1,
  output logic [11:0] word = 12'h000,
  output logic hold = 1'b0,
  output logic busy = 1'b0
);
  int idx = 0;
  always @(posedge clk) begin
    if (start && !busy) begin
      busy <= 1'b1;
      strobe_n <= 1'b0;
      word <= words[11:0];
      idx <= 0;
    end else if (busy && hold) begin
      hold <= 1'b0;
    end else if (busy && loadReady) begin
      if (idx == int'(len)) begin
        busy <= 1'b0;
        strobe_n <= 1'b1;
        // Released bus flips so a stale word cannot pass for a good one
        word <= ~word;
      end else begin
        idx <= idx + 1;
        word <= words[(idx+1)*12 +: 12];
        hold <= slow && idx == 1;
      end
    end
  end
endmodule // clif_host

// ==== bench/coefficient_load_interface_tb_top.sv ====
`timescale 1ns/1ps
module coefficient_load_interface_tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hStart = 1'b0, vStart = 1'b0, hSlow = 1'b0, ctrlReady = 1'b0;
  logic [4:0] hLen = 5'h00, vLen = 5'h00;
  logic [215:0] hWords = '0, vWords = '0;
  logic hStb_n, vStb_n, hHold, vHold, hBusy, vBusy, loadReady;
  logic [11:0] hWord, vWord;
  logic horizCoefWrite, vertCoefWrite, ctrlValid;
  logic [8:0] horizCoefAddr, vertCoefAddr;
  logic [95:0] horizCoefData, vertCoefData;
  clif_pkg::clif_rec_type ctrlRec;
  logic [107:0] d = {12'h143, 12'hF20, 12'h832, 12'h701, 12'h9E3, 12'hC76, 12'h543, 12'h210,
    12'h00A};
  int fails = 0;
  int checked = 0;
  int n;

  clif_top #(.FIFO_DEPTH(2)) i_dut (.clk(clk), .rst_n(rst_n),
    .horiz_load_strobe_n(hStb_n), .horiz_load_word(hWord), .horiz_load_hold(hHold),
    .vert_load_strobe_n(vStb_n), .vert_load_word(vWord), .vert_load_hold(vHold),
    .loadReady(loadReady), .horizCoefWrite(horizCoefWrite), .horizCoefAddr(horizCoefAddr),
    .horizCoefData(horizCoefData), .vertCoefWrite(vertCoefWrite), .vertCoefAddr(vertCoefAddr),
    .vertCoefData(vertCoefData), .ctrlValid(ctrlValid), .ctrlReady(ctrlReady), .ctrlRec(ctrlRec));
  clif_host i_hhost (.clk(clk), .loadReady(loadReady), .start(hStart), .len(hLen),
    .words(hWords), .slow(hSlow), .strobe_n(hStb_n), .word(hWord), .hold(hHold), .busy(hBusy));
  clif_host i_vhost (.clk(clk), .loadReady(loadReady), .start(vStart), .len(vLen),
    .words(vWords), .slow(1'b0), .strobe_n(vStb_n), .word(vWord), .hold(vHold), .busy(vBusy));

  task automatic check(input logic [95:0] got, input logic [95:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("fails=%0d checked=%0d", fails, checked);
    if (fails == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Waits at negedges for a flag, counting cycles; bounded so a hang shows as a count
  // Flag 0 is horizCoefWrite, 1 is ctrlValid, 2 is loadReady
  task automatic wait_flag(input int which, input logic lvl);
    logic flag;
    n = 0;
    do begin
      @(negedge clk);
      n++;
      flag = (which == 0) ? horizCoefWrite : (which == 1) ? ctrlValid : loadReady;
    end while (flag !== lvl && n < 40);
    if (flag !== lvl) begin
      fails++;
      $display("wrong value at %0t: wait for flag %0d timed out", $time, which);
    end
  endtask

  task automatic pop(input logic [43:0] exp);
    wait_flag(1, 1'b1);
    check(96'(ctrlRec), 96'(exp), "ctrlRec");
    @(posedge clk) ctrlReady <= 1'b1;
    @(posedge clk) ctrlReady <= 1'b0;
    @(negedge clk);
  endtask

  task automatic coef_both;
    @(posedge clk);
    hWords <= 216'(d);
    vWords <= 216'({d[107:12], 12'h005});
    hLen <= 5'h08;
    vLen <= 5'h08;
    hStart <= 1'b1;
    vStart <= 1'b1;
    @(posedge clk);
    hStart <= 1'b0;
    vStart <= 1'b0;
    wait_flag(0, 1'b1);
    check(96'(n), 96'(10), "coef cycles");
    check(96'(vertCoefWrite), 96'(1), "vert write");
    check(96'(horizCoefAddr), 96'(12'h00A), "h addr");
    check(96'(vertCoefAddr), 96'(12'h005), "v addr");
    check(horizCoefData, d[107:12], "h data");
    check(vertCoefData, d[107:12], "v data");
    @(negedge clk);
    check(96'(horizCoefWrite), 96'(0), "pulse");
    check(96'(ctrlValid), 96'(0), "no ctrl");
  endtask

  task automatic coef_and_ctrl;
    @(posedge clk);
    hWords <= 216'({12'h456, 12'h123, 12'hC0A, d[107:12], 12'h003});
    vWords <= 216'({12'h044, 12'h033, 12'h022, 12'h011, 12'hA03});
    hLen <= 5'h0B;
    vLen <= 5'h04;
    hStart <= 1'b1;
    vStart <= 1'b1;
    @(posedge clk);
    hStart <= 1'b0;
    vStart <= 1'b0;
    wait_flag(0, 1'b1);
    check(96'(n), 96'(10), "mixed coef cycles");
    check(96'(horizCoefAddr), 96'(9'h003), "mixed h addr");
    check(horizCoefData, d[107:12], "mixed h data");
    check(96'(vertCoefWrite), 96'(0), "no v coef");
    pop({3'h5, 9'h003, 32'h44332211});
    pop({3'h6, 9'h00A, 32'h00456123});
  endtask

  task automatic round_paused;
    @(posedge clk);
    hWords <= 216'({12'h076, 12'h083, 12'h0F4, 12'h0A2, 12'h80C});
    hLen <= 5'h04;
    hSlow <= 1'b1;
    hStart <= 1'b1;
    @(posedge clk);
    hStart <= 1'b0;
    wait_flag(1, 1'b1);
    check(96'(n), 96'(8), "round cycles");
    pop({3'h4, 9'h00C, 32'h7683F4A2});
    @(posedge clk) hSlow <= 1'b0;
  endtask

  task automatic prio_collision;
    @(posedge clk);
    vWords <= 216'({12'h743, 12'h390, 12'hE07});
    vLen <= 5'h02;
    hWords <= 216'({12'h00F, 12'h402, 12'h003, 12'h204});
    hLen <= 5'h03;
    vStart <= 1'b1;
    @(posedge clk);
    vStart <= 1'b0;
    hStart <= 1'b1;
    @(posedge clk);
    hStart <= 1'b0;
    wait_flag(2, 1'b0);
    check(96'(loadReady), 96'(0), "fifo full");
    @(posedge clk);
    hWords <= 216'({12'h00A, 12'h201});
    hLen <= 5'h01;
    hStart <= 1'b1;
    @(posedge clk) hStart <= 1'b0;
    repeat (10) @(negedge clk);
    check(96'(hBusy), 96'(1), "stalled");
    pop({3'h7, 9'h007, 32'h00743390});
    pop({3'h2, 9'h002, 32'h0000000F});
    pop({3'h1, 9'h001, 32'h0000000A});
    repeat (3) @(negedge clk);
    check(96'(ctrlValid), 96'(0), "drained");
  endtask

  initial begin
    forever #20 clk = ~clk;
  end

  initial begin
    #40000;
    fails++;
    report_and_stop();
  end

  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    coef_both();
    coef_and_ctrl();
    round_paused();
    prio_collision();
    report_and_stop();
  end
endmodule // coefficient_load_interface_tb_top
